// ===== hdl/flag_eval.sv
// extension, unnormalized, negative and zero flag evaluation
`timescale 1ns/1ps
module flag_eval
  import negate_pkg::*;
(
  // flag request and answer
  flag_if.calc fl
);

  // ---------------------------------------------------------------
  // extension and normalisation on the wide value
  // ---------------------------------------------------------------
  // byte results arrive left aligned and long results sign-extended to 36 bits, so one test serves all widths
  function automatic logic ext_in_use(input logic [35:0] v);
    ext_in_use = !((&v[35:31]) || !(|v[35:31]));
  endfunction : ext_in_use

  always_comb
  begin
    fl.e_flag = ext_in_use(fl.wide_val);
    fl.u_flag = (fl.wide_val[31] == fl.wide_val[30]);
    case (fl.size)
      size_byte:
      begin
        fl.n_flag = fl.narrow_val[7];
        fl.z_flag = (fl.narrow_val[7:0] == 8'h00);
      end
      size_long:
      begin
        fl.n_flag = fl.narrow_val[31];
        fl.z_flag = (fl.narrow_val == 32'h0000_0000);
      end
      default:
      begin
        fl.n_flag = fl.wide_val[35];
        fl.z_flag = (fl.wide_val == 36'h0_0000_0000);
      end
    endcase
  end

endmodule : flag_eval

// ===== hdl/negate_instruction_unit.sv
// negate instruction datapath: register, byte memory and long memory negate
`timescale 1ns/1ps
// Behaviour
// - register negate sets N from MSB, Z on zero
// - register negate sets V on overflow
// - register negate sets C on borrow from MSB
// - register negate with move: one word, one cycle
// - plain register negate takes one cycle
// - storing the arithmetic destination to memory is allowed
// - byte negate sign-extends byte to 20 bits
// - byte negate writes back only low byte
// - byte N,Z,V,C from 8 bits; E,U from 20
// - byte negate absolute addresses are byte addresses
// - word address is byte address halved, odd upper
// - byte negate ignores saturation, never limited
// - byte E on extension use, U unnormalized
// - byte N from bit 7, C borrow bit 7
// - byte negate three or four cycles by address size
// - long negate writes back 32-bit result
// - long flags from 32 bits; E,U from 36
// - 16-bit destination sign-extended, sixteen zeros appended
// - most negative value limited only with saturation
module negate_instruction_unit
  import negate_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // software register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // operation request
  input  wire logic        op_valid,
  input  wire op_kind_t    op_kind,
  input  wire logic        op_long_addr,
  input  wire logic        op_dest_16,
  input  wire logic [35:0] op_operand,
  input  wire logic [23:0] op_addr,
  output logic             op_ready,
  // parallel move request
  input  wire move_kind_t  move_kind,
  input  wire logic        move_plus_n,
  input  wire logic [23:0] move_ptr,
  input  wire logic [23:0] move_offset,
  input  wire logic [15:0] move_src,
  input  wire move_reg_t   move_dst,
  // results
  output logic             op_done,
  output logic      [35:0] res_value,
  output logic      [7:0]  condition_code_byte,
  output logic             ptr_valid,
  output logic      [23:0] ptr_value,
  output logic             load_valid,
  output logic      [15:0] load_data,
  output move_reg_t        load_dst,
  // data memory
  output logic      [23:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [3:0]  mem_be,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_t      state_reg,      state_next;
  op_kind_t    kind_reg,       kind_next;
  logic        odd_reg,        odd_next;
  logic [23:0] addr_reg,       addr_next;
  logic        sat_reg,        sat_next;
  logic [7:0]  ccr_reg,        ccr_next;
  logic [15:0] rdata_reg,      rdata_next;
  logic        ready_reg,      ready_next;
  logic        done_reg,       done_next;
  logic [35:0] res_reg,        res_next;
  logic        pvalid_reg,     pvalid_next;
  logic [23:0] ptr_reg,        ptr_next;
  logic        lpend_reg,      lpend_next;
  move_reg_t   lpdst_reg,      lpdst_next;
  logic        lvalid_reg,     lvalid_next;
  logic [15:0] ldata_reg,      ldata_next;
  move_reg_t   ldst_reg,       ldst_next;
  logic [23:0] maddr_reg,      maddr_next;
  logic        mrd_reg,        mrd_next;
  logic        mwr_reg,        mwr_next;
  logic [3:0]  mbe_reg,        mbe_next;
  logic [31:0] mwdata_reg,     mwdata_next;

  flag_if fl ();

  flag_eval u_flag_eval (
    .fl (fl.calc)
  );

  // ---------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------
  function automatic logic [35:0] widen_16(input logic [15:0] v);
    widen_16 = {{4{v[15]}}, v, 16'h0000};
  endfunction : widen_16

  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic odd);
    pick_byte = odd ? w[15:8] : w[7:0];
  endfunction : pick_byte

  // ---------------------------------------------------------------
  // datapath terms
  // ---------------------------------------------------------------
  logic        accept;
  logic [35:0] reg_operand;
  logic [35:0] reg_neg;
  logic        reg_ovf;
  logic [35:0] reg_result;
  logic [7:0]  mem_byte;
  logic [19:0] byte_neg;
  logic [31:0] mem_long;
  logic [35:0] long_neg;

  always_comb
  begin
    accept      = ready_reg && op_valid;
    reg_operand = op_dest_16 ? widen_16(op_operand[15:0]) : op_operand;
    reg_neg     = 36'h0_0000_0000 - reg_operand;
    reg_ovf     = (reg_operand == MIN_ACC);
    // negating the most negative value leaves it unchanged unless limited
    reg_result  = (reg_ovf && sat_reg) ? SAT_LIMIT : reg_neg;
    mem_byte    = pick_byte(mem_rdata, odd_reg);
    byte_neg    = 20'h0_0000 - {{12{mem_byte[7]}}, mem_byte};
    mem_long    = mem_rdata;
    long_neg    = 36'h0_0000_0000 - {{4{mem_long[31]}}, mem_long};
    // flag evaluator sees the memory result only while its data are on the bus
    if (state_reg == st_wait && kind_reg == negate_byte_memory_op)
    begin
      fl.wide_val   = {byte_neg, 16'h0000};
      fl.narrow_val = {24'h00_0000, byte_neg[7:0]};
      fl.size       = size_byte;
    end
    else if (state_reg == st_wait)
    begin
      fl.wide_val   = long_neg;
      fl.narrow_val = long_neg[31:0];
      fl.size       = size_long;
    end
    else
    begin
      fl.wide_val   = reg_result;
      fl.narrow_val = reg_result[35:4];
      fl.size       = size_acc;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next  = state_reg;
    kind_next   = kind_reg;
    odd_next    = odd_reg;
    addr_next   = addr_reg;
    sat_next    = sat_reg;
    ccr_next    = ccr_reg;
    rdata_next  = 16'h0000;
    done_next   = 1'b0;
    res_next    = res_reg;
    pvalid_next = 1'b0;
    ptr_next    = ptr_reg;
    lpend_next  = 1'b0;
    lpdst_next  = lpdst_reg;
    lvalid_next = 1'b0;
    ldata_next  = ldata_reg;
    ldst_next   = ldst_reg;
    maddr_next  = maddr_reg;
    mrd_next    = 1'b0;
    mwr_next    = 1'b0;
    mbe_next    = mbe_reg;
    mwdata_next = mwdata_reg;

    // software access; hardware flag updates below take precedence
    if (reg_wr && reg_addr == CTRL_OFFSET)
    begin
      sat_next = reg_wdata[CTRL_SAT_POS];
    end
    if (reg_wr && reg_addr == CCR_OFFSET)
    begin
      ccr_next = reg_wdata[7:0];
    end
    if (reg_rd)
    begin
      case (reg_addr)
        CTRL_OFFSET: rdata_next = {15'h0000, sat_reg};
        CCR_OFFSET:  rdata_next = {8'h00, ccr_reg};
        default:     rdata_next = 16'h0000;
      endcase
    end

    // parallel read data return one cycle after the strobe
    if (lpend_reg)
    begin
      lvalid_next = 1'b1;
      ldata_next  = mem_rdata[15:0];
      ldst_next   = lpdst_reg;
    end

    case (state_reg)
      st_idle:
      begin
        if (accept && op_kind == negate_register_op)
        begin
          done_next                = 1'b1;
          res_next                 = reg_result;
          ccr_next[CCR_N_POS]      = fl.n_flag;
          ccr_next[CCR_Z_POS]      = fl.z_flag;
          ccr_next[CCR_V_POS]      = reg_ovf;
          ccr_next[CCR_C_POS]      = (reg_operand != 36'h0_0000_0000);
          ccr_next[CCR_E_POS]      = fl.e_flag;
          ccr_next[CCR_U_POS]      = fl.u_flag;
          ccr_next[CCR_L_POS]      = ccr_reg[CCR_L_POS] | reg_ovf;
          if (move_kind == move_read || move_kind == move_write)
          begin
            pvalid_next = 1'b1;
            ptr_next    = move_ptr + (move_plus_n ? move_offset : PTR_STEP);
            maddr_next  = move_ptr;
            mbe_next    = BE_WORD;
          end
          if (move_kind == move_read)
          begin
            // a read into the arithmetic destination is not guarded here
            mrd_next   = 1'b1;
            lpend_next = 1'b1;
            lpdst_next = move_dst;
          end
          if (move_kind == move_write)
          begin
            // the stored value is the one presented before this negate
            mwr_next    = 1'b1;
            mwdata_next = {16'h0000, move_src};
          end
        end
        else if (accept && (op_kind == negate_byte_memory_op ||
                            op_kind == negate_long_memory_op))
        begin
          kind_next = op_kind;
          if (op_kind == negate_byte_memory_op)
          begin
            odd_next  = op_addr[0];
            addr_next = {1'b0, op_addr[23:1]};
          end
          else
          begin
            odd_next  = 1'b0;
            addr_next = op_addr;
          end
          // an extended absolute address costs one more fetch cycle
          if (op_long_addr)
          begin
            state_next = st_addr;
          end
          else
          begin
            state_next = st_read;
            mrd_next   = 1'b1;
          end
        end
      end
      st_addr:
      begin
        state_next = st_read;
        mrd_next   = 1'b1;
      end
      st_read:
      begin
        state_next = st_wait;
      end
      st_wait:
      begin
        state_next          = st_write;
        mwr_next            = 1'b1;
        done_next           = 1'b1;
        ccr_next[CCR_N_POS] = fl.n_flag;
        ccr_next[CCR_Z_POS] = fl.z_flag;
        ccr_next[CCR_E_POS] = fl.e_flag;
        ccr_next[CCR_U_POS] = fl.u_flag;
        if (kind_reg == negate_byte_memory_op)
        begin
          res_next            = {{16{byte_neg[19]}}, byte_neg};
          mbe_next            = odd_reg ? BE_HIGH_BYTE : BE_LOW_BYTE;
          mwdata_next         = {16'h0000, byte_neg[7:0], byte_neg[7:0]};
          ccr_next[CCR_V_POS] = (mem_byte == MIN_BYTE);
          ccr_next[CCR_C_POS] = (mem_byte != 8'h00);
        end
        else
        begin
          res_next            = long_neg;
          mbe_next            = BE_LONG;
          mwdata_next         = long_neg[31:0];
          ccr_next[CCR_V_POS] = (mem_long == MIN_LONG);
          ccr_next[CCR_C_POS] = (mem_long != 32'h0000_0000);
        end
      end
      st_write:
      begin
        state_next = st_idle;
      end
      default:
      begin
        state_next = st_idle;
      end
    endcase

    // the address moves with the read strobe of a memory negate
    if (mrd_next && state_next == st_read)
    begin
      maddr_next = addr_next;
      mbe_next   = (kind_next == negate_long_memory_op) ? BE_LONG : BE_WORD;
    end
    ready_next = (state_next == st_idle);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg  <= st_idle;
      kind_reg   <= negate_register_op;
      odd_reg    <= 1'b0;
      addr_reg   <= 24'h00_0000;
      sat_reg    <= SAT_RESET;
      ccr_reg    <= CCR_RESET;
      rdata_reg  <= 16'h0000;
      ready_reg  <= 1'b0;
      done_reg   <= 1'b0;
      res_reg    <= 36'h0_0000_0000;
      pvalid_reg <= 1'b0;
      ptr_reg    <= 24'h00_0000;
      lpend_reg  <= 1'b0;
      lpdst_reg  <= input_register_zero;
      lvalid_reg <= 1'b0;
      ldata_reg  <= 16'h0000;
      ldst_reg   <= input_register_zero;
      maddr_reg  <= 24'h00_0000;
      mrd_reg    <= 1'b0;
      mwr_reg    <= 1'b0;
      mbe_reg    <= 4'h0;
      mwdata_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg  <= state_next;
      kind_reg   <= kind_next;
      odd_reg    <= odd_next;
      addr_reg   <= addr_next;
      sat_reg    <= sat_next;
      ccr_reg    <= ccr_next;
      rdata_reg  <= rdata_next;
      ready_reg  <= ready_next;
      done_reg   <= done_next;
      res_reg    <= res_next;
      pvalid_reg <= pvalid_next;
      ptr_reg    <= ptr_next;
      lpend_reg  <= lpend_next;
      lpdst_reg  <= lpdst_next;
      lvalid_reg <= lvalid_next;
      ldata_reg  <= ldata_next;
      ldst_reg   <= ldst_next;
      maddr_reg  <= maddr_next;
      mrd_reg    <= mrd_next;
      mwr_reg    <= mwr_next;
      mbe_reg    <= mbe_next;
      mwdata_reg <= mwdata_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata           = rdata_reg;
  assign op_ready            = ready_reg;
  assign op_done             = done_reg;
  assign res_value           = res_reg;
  assign condition_code_byte = ccr_reg;
  assign ptr_valid           = pvalid_reg;
  assign ptr_value           = ptr_reg;
  assign load_valid          = lvalid_reg;
  assign load_data           = ldata_reg;
  assign load_dst            = ldst_reg;
  assign mem_addr            = maddr_reg;
  assign mem_rd              = mrd_reg;
  assign mem_wr              = mwr_reg;
  assign mem_be              = mbe_reg;
  assign mem_wdata           = mwdata_reg;

endmodule : negate_instruction_unit

// ===== pkg/flag_if.sv
// interface between the negate datapath and its flag evaluator
`timescale 1ns/1ps
interface flag_if;
  import negate_pkg::*;

  logic [35:0] wide_val;
  logic [31:0] narrow_val;
  flag_size_t  size;
  logic        e_flag;
  logic        u_flag;
  logic        n_flag;
  logic        z_flag;

  modport calc (
    input  wide_val,
    input  narrow_val,
    input  size,
    output e_flag,
    output u_flag,
    output n_flag,
    output z_flag
  );

  modport user (
    output wide_val,
    output narrow_val,
    output size,
    input  e_flag,
    input  u_flag,
    input  n_flag,
    input  z_flag
  );
endinterface : flag_if

// ===== pkg/negate_pkg.sv
// shared constants and types for the negate instruction unit
package negate_pkg;

  // ---------------------------------------------------------------
  // software register port
  // ---------------------------------------------------------------
  localparam logic [1:0]  CTRL_OFFSET    = 2'h0;
  localparam logic [1:0]  CCR_OFFSET     = 2'h1;
  localparam int          CTRL_SAT_POS   = 0;
  localparam logic        SAT_RESET      = 1'b0;
  localparam logic [7:0]  CCR_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // condition code byte layout
  // ---------------------------------------------------------------
  localparam int CCR_C_POS  = 0;
  localparam int CCR_V_POS  = 1;
  localparam int CCR_Z_POS  = 2;
  localparam int CCR_N_POS  = 3;
  localparam int CCR_U_POS  = 4;
  localparam int CCR_E_POS  = 5;
  localparam int CCR_L_POS  = 6;
  localparam int CCR_SZ_POS = 7;

  // ---------------------------------------------------------------
  // data values
  // ---------------------------------------------------------------
  localparam logic [35:0] MIN_ACC        = 36'h8_0000_0000;
  localparam logic [35:0] SAT_LIMIT      = 36'hF_8000_0000;
  localparam logic [7:0]  MIN_BYTE       = 8'h80;
  localparam logic [31:0] MIN_LONG       = 32'h8000_0000;
  localparam logic [23:0] PTR_STEP       = 24'h00_0001;
  localparam logic [3:0]  BE_LOW_BYTE    = 4'h1;
  localparam logic [3:0]  BE_HIGH_BYTE   = 4'h2;
  localparam logic [3:0]  BE_WORD        = 4'h3;
  localparam logic [3:0]  BE_LONG        = 4'hF;

  // ---------------------------------------------------------------
  // cycle counts, from acceptance to the done pulse
  // ---------------------------------------------------------------
  localparam int REG_OP_CYCLES       = 1;
  localparam int MEM_OP_SHORT_CYCLES = 3;
  localparam int MEM_OP_LONG_CYCLES  = 4;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    negate_register_op    = 2'b00,
    negate_byte_memory_op = 2'b01,
    negate_long_memory_op = 2'b10,
    op_none               = 2'b11
  } op_kind_t;

  typedef enum logic [1:0] {
    move_none  = 2'b00,
    move_read  = 2'b01,
    move_write = 2'b10,
    move_rsvd  = 2'b11
  } move_kind_t;

  typedef enum logic [2:0] {
    input_register_zero = 3'b000,
    second_input_high   = 3'b001,
    second_input_low    = 3'b010,
    accum_a             = 3'b011,
    accum_b             = 3'b100,
    accum_c             = 3'b101,
    accum_one_mid_word  = 3'b110,
    accum_two_mid_word  = 3'b111
  } move_reg_t;

  typedef enum logic [1:0] {
    size_acc  = 2'b00,
    size_byte = 2'b01,
    size_long = 2'b10,
    size_rsvd = 2'b11
  } flag_size_t;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_read = 3'b010,
    st_wait = 3'b011,
    st_write = 3'b100
  } state_t;

endpackage : negate_pkg

// ===== sim/negate_checker.sv
// concurrent checks on the negate instruction unit ports
`timescale 1ns/1ps
module negate_checker
  import negate_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // requests
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire op_kind_t    op_kind,
  input wire logic        op_long_addr,
  input wire logic        op_dest_16,
  input wire logic [35:0] op_operand,
  input wire logic [23:0] op_addr,
  input wire move_kind_t  move_kind,
  input wire logic        move_plus_n,
  input wire logic [23:0] move_ptr,
  input wire logic [23:0] move_offset,
  input wire logic [15:0] move_src,
  // results and memory
  input wire logic        op_done,
  input wire logic [35:0] res_value,
  input wire logic [7:0]  condition_code_byte,
  input wire logic        ptr_valid,
  input wire logic [23:0] ptr_value,
  input wire logic [23:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [3:0]  mem_be,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  wire take     = op_valid && op_ready && op_kind != op_none;
  wire take_reg = take && op_kind == negate_register_op;
  wire take_bs  = take && op_kind == negate_byte_memory_op && !op_long_addr;
  wire take_bl  = take && op_kind == negate_byte_memory_op && op_long_addr;

  // fetch and wait phase of a memory negate
  sequence mem_wait_s;
    !op_done ##1 !op_done;
  endsequence

  reg_cycle_a: assert property (take_reg |=> op_done)
    else $error("register negate not done in one cycle");
  byte_short_a: assert property (take_bs |=> mem_wait_s ##1 (op_done && mem_wr))
    else $error("short byte negate timing wrong");
  byte_long_a: assert property (take_bl |=> mem_wait_s ##1 !op_done ##1 op_done)
    else $error("long byte negate timing wrong");
  byte_addr_a: assert property (take_bs |=> mem_rd && mem_addr == {1'b0, $past(op_addr[23:1])})
    else $error("byte word address wrong");
  byte_lane_a: assert property (take_bs ##3 1'b1 |->
    mem_be == ($past(op_addr[0], 3) ? BE_HIGH_BYTE : BE_LOW_BYTE))
    else $error("byte lane wrong");
  low_wb_a: assert property (mem_wr && mem_be == BE_LOW_BYTE |->
    mem_wdata[7:0] == 8'h00 - $past(mem_rdata[7:0]))
    else $error("byte write back wrong");
  long_wb_a: assert property (mem_wr && mem_be == BE_LONG |->
    mem_wdata == 32'h0000_0000 - $past(mem_rdata))
    else $error("long write back wrong");
  move_store_a: assert property (take_reg && move_kind == move_write |=>
    mem_wr && mem_be == BE_WORD && mem_wdata[15:0] == $past(move_src))
    else $error("parallel store wrong");
  ptr_step_a: assert property (take_reg && move_kind != move_none |=> ptr_valid &&
    ptr_value == $past(move_ptr) + ($past(move_plus_n) ? $past(move_offset) : PTR_STEP))
    else $error("pointer update wrong");
  reg_nz_a: assert property (take_reg |=> condition_code_byte[CCR_N_POS] == res_value[35] &&
    condition_code_byte[CCR_Z_POS] == (res_value == 36'h0_0000_0000))
    else $error("register N or Z wrong");
  dest16_a: assert property (take_reg && op_dest_16 |=> res_value == 36'h0_0000_0000 -
    {{4{$past(op_operand[15])}}, $past(op_operand[15:0]), 16'h0000})
    else $error("16-bit destination result wrong");
endmodule : negate_checker

bind negate_instruction_unit negate_checker negate_checker_i (.*);

// ===== sim/testbench.sv
// self-checking bench for the negate instruction unit
`timescale 1ns/1ps
module testbench;
  import negate_pkg::*;
  logic        core_clk, rst, reg_wr, reg_rd, op_valid, op_ready, op_long_addr, op_dest_16;
  logic        move_plus_n, op_done, ptr_valid, load_valid, mem_rd, mem_wr, r_wr;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, move_src, load_data, d;
  logic [35:0] op_operand, res_value, r_res;
  logic [23:0] op_addr, move_ptr, move_offset, ptr_value, mem_addr, r_addr, r_ptr;
  logic [7:0]  condition_code_byte, r_ccr;
  logic [3:0]  mem_be, r_be;
  logic [31:0] mem_wdata, mem_rdata, r_wd;
  op_kind_t    op_kind;
  move_kind_t  move_kind;
  move_reg_t   move_dst, load_dst;
  int          fails, n_tests, cyc;

  negate_instruction_unit negate_instruction_unit_i (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd_reg

  // memory answers with md for the whole operation
  task automatic run_op(input op_kind_t k, input logic la, input logic d16,
                        input logic [35:0] opd, input logic [23:0] a, input logic [31:0] md,
                        input move_kind_t mk, input logic pn);
    cyc = 0;
    while (op_ready !== 1'b1)
    begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    op_valid     <= 1'b1;
    op_kind      <= k;
    op_long_addr <= la;
    op_dest_16   <= d16;
    op_operand   <= opd;
    op_addr      <= a;
    mem_rdata    <= md;
    move_kind    <= mk;
    move_plus_n  <= pn;
    @(posedge core_clk);
    op_valid  <= 1'b0;
    move_kind <= move_none;
    while (cyc < 8)
    begin
      cyc++;
      #1;
      if (op_done === 1'b1)
        break;
      @(posedge core_clk);
    end
    {r_res, r_ccr, r_wd, r_be, r_addr, r_wr, r_ptr} =
      {res_value, condition_code_byte, mem_wdata, mem_be, mem_addr, mem_wr, ptr_value};
  endtask : run_op

  task automatic reg_case(input logic d16, input logic [35:0] opd, input logic [35:0] res,
                          input logic [3:0] f);
    run_op(negate_register_op, 1'b0, d16, opd, 24'h00_0000, 32'h0, move_none, 1'b0);
    chk("cycles", REG_OP_CYCLES, cyc);
    chk("result", res, r_res);
    chk("flags", f, r_ccr[3:0]);
  endtask : reg_case

  task automatic byte_case(input logic [23:0] a, input logic la, input logic [31:0] md,
                           input logic [3:0] be, input logic [7:0] b, input logic [35:0] res,
                           input logic [3:0] f);
    run_op(negate_byte_memory_op, la, 1'b0, 36'h0, a, md, move_none, 1'b0);
    chk("cycles", la ? MEM_OP_LONG_CYCLES : MEM_OP_SHORT_CYCLES, cyc);
    chk("word_addr", a >> 1, r_addr);
    chk("lanes", be, r_be);
    chk("byte", b, (be == BE_HIGH_BYTE) ? r_wd[15:8] : r_wd[7:0]);
    chk("result", res, r_res);
    chk("flags", f, r_ccr[3:0]);
  endtask : byte_case

  task automatic long_case(input logic [23:0] a, input logic la, input logic [31:0] md,
                           input logic [31:0] w, input logic [3:0] f);
    run_op(negate_long_memory_op, la, 1'b0, 36'h0, a, md, move_none, 1'b0);
    chk("cycles", la ? MEM_OP_LONG_CYCLES : MEM_OP_SHORT_CYCLES, cyc);
    chk("addr", a, r_addr);
    chk("long_write", {BE_LONG, w}, {r_be, r_wd});
    chk("flags", f, r_ccr[3:0]);
  endtask : long_case

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial
  begin
    repeat (3000) @(posedge core_clk);
    fails++;
    $display("ERROR watchdog expected end seen hang");
    report_and_stop();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {rst, reg_wr, reg_rd, op_valid, op_long_addr, op_dest_16, move_plus_n} = 7'h41;
    {reg_addr, reg_wdata, op_operand, op_addr, mem_rdata} = '0;
    {op_kind, move_kind, move_dst} = {op_none, move_none, accum_a};
    {move_ptr, move_offset, move_src} = {24'h00_0100, 24'h00_0010, 16'h1234};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd_reg(CTRL_OFFSET, d);
    chk("ctrl", SAT_RESET, d);
    rd_reg(CCR_OFFSET, d);
    chk("ccr", CCR_RESET, d);
    wr_reg(CCR_OFFSET, 16'h00A5);
    rd_reg(CCR_OFFSET, d);
    chk("ccr", 16'h00A5, d);
    rd_reg(2'h3, d);
    chk("unmapped", 16'h0000, d);
    $display("test registers done");
    reg_case(1'b0, 36'h0_00AA_FF00, 36'hF_FF55_0100, 4'h9);
    reg_case(1'b0, 36'h0_0000_0000, 36'h0_0000_0000, 4'h4);
    reg_case(1'b0, 36'h7_FFFF_FFFF, 36'h8_0000_0001, 4'h9);
    reg_case(1'b1, 36'h0_0000_0001, 36'hF_FFFF_0000, 4'h9);
    reg_case(1'b0, MIN_ACC, MIN_ACC, 4'hB);
    chk("limit", 1'b1, r_ccr[CCR_L_POS]);
    wr_reg(CTRL_OFFSET, 16'h0001);
    reg_case(1'b0, MIN_ACC, SAT_LIMIT, 4'hB);
    $display("test register negate done");
    run_op(negate_register_op, 1'b0, 1'b0, 36'h1, 24'h0, 32'h0, move_write, 1'b0);
    chk("cycles", REG_OP_CYCLES, cyc);
    chk("store", {1'b1, BE_WORD, 16'h1234}, {r_wr, r_be, r_wd[15:0]});
    chk("ptr", 24'h00_0101, r_ptr);
    run_op(negate_register_op, 1'b0, 1'b0, 36'h1, 24'h0, 32'h5A5A, move_read, 1'b1);
    chk("load_addr", 24'h00_0100, r_addr);
    chk("ptr", 24'h00_0110, r_ptr);
    @(posedge core_clk);
    #1;
    chk("load", {1'b1, accum_a, 16'h5A5A}, {load_valid, load_dst, load_data});
    $display("test parallel move done");
    byte_case(24'h00_3065, 1'b0, 32'h0000_4400, BE_HIGH_BYTE, 8'hBC,
              36'hF_FFFF_FFBC, 4'h9);
    byte_case(24'h00_3064, 1'b1, 32'h0000_0080, BE_LOW_BYTE, 8'h80,
              36'h0_0000_0080, 4'hB);
    byte_case(24'h00_0011, 1'b0, 32'h0, BE_HIGH_BYTE, 8'h00, 36'h0, 4'h4);
    $display("test byte negate done");
    long_case(24'h00_2000, 1'b0, 32'h00AA_FF00, 32'hFF55_0100, 4'h9);
    long_case(24'h01_2346, 1'b1, 32'h8000_0000, 32'h8000_0000, 4'hB);
    $display("test long negate done");
    report_and_stop();
  end
endmodule : testbench
